// file: hw/bwc_pkg.sv
// Package: offsets, field layouts and reset values of the bridge window registers
package bwc_pkg;

    // Configuration byte offsets
    localparam logic [7:0] IO_LIMIT_OFS      = 8'h1D;
    localparam logic [7:0] BUS_STATUS_LO_OFS = 8'h1E;
    localparam logic [7:0] BUS_STATUS_HI_OFS = 8'h1F;
    localparam logic [7:0] MEM_BASE_LO_OFS   = 8'h20;
    localparam logic [7:0] MEM_BASE_HI_OFS   = 8'h21;
    localparam logic [7:0] MEM_LIMIT_LO_OFS  = 8'h22;
    localparam logic [7:0] MEM_LIMIT_HI_OFS  = 8'h23;

    // Field layout of the writable nibbles
    localparam int         TOP_NIBBLE_LSB = 4;
    localparam int         TOP_NIBBLE_MSB = 7;

    // Read-only and reset values
    localparam logic [3:0]  IO_WIDTH_CODE   = 4'h1;
    localparam logic [3:0]  RSVD_NIBBLE     = 4'h0;
    localparam logic [3:0]  IO_TOP_RESET    = 4'h0;
    localparam logic [11:0] MEM_BITS_RESET  = 12'h000;
    localparam logic [7:0]  UNMAPPED_BYTE   = 8'h00;

    // Fill values for the window bounds
    localparam logic [11:0] IO_LOW_ZEROS  = 12'h000;
    localparam logic [11:0] IO_LOW_ONES   = 12'hFFF;
    localparam logic [19:0] MEM_LOW_ZEROS = 20'h0_0000;
    localparam logic [19:0] MEM_LOW_ONES  = 20'hF_FFFF;

    // Internal bus status, every field hardwired
    typedef struct packed {
        logic       parityDetectedFlag;
        logic       systemErrorSeenFlag;
        logic       initiatorAbortSeenFlag;
        logic       targetAbortSeenFlag;
        logic       targetAbortSentFlag;
        logic [1:0] selectTiming;
        logic       initiatorParityFlag;
        logic       backToBackCapable;
        logic       reservedBit6;
        logic       doubleRateCapable;
        logic [4:0] reservedLow;
    } bwc_status_t;

    localparam bwc_status_t BUS_STATUS_VALUE = '{
        parityDetectedFlag:     1'b0,
        systemErrorSeenFlag:    1'b0,
        initiatorAbortSeenFlag: 1'b0,
        targetAbortSeenFlag:    1'b0,
        targetAbortSentFlag:    1'b0,
        selectTiming:           2'h0,
        initiatorParityFlag:    1'b0,
        backToBackCapable:      1'b0,
        reservedBit6:           1'b0,
        doubleRateCapable:      1'b0,
        reservedLow:            5'h00
    };

    // One address window, both bounds inclusive
    typedef struct packed {
        logic [31:0] bottom;
        logic [31:0] top;
    } bwc_window_t;

    // One byte-wide configuration access
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] offset;
        logic [7:0] wrData;
    } bwc_cfg_req_t;

endpackage : bwc_pkg

// file: hw/bwc_regs.sv
// Bridge window registers: I/O limit, internal bus status, memory base and limit
// How it works
// - I/O limit bits 7:4 are writable and give I/O top address bits 15:12.
// - I/O window top has its twelve low address bits all ones.
// - I/O top bits 31:16 come from the separate upper limit input.
// - I/O limit bits 3:0 read 1, marking 32-bit I/O; writes ignored.
// - I/O base and limit decide whether an I/O access is forwarded.
// - I/O limit register resets to 01h.
// - Internal bus error bits 15..11 and 8 always read zero.
// - Select timing bits 10:9 are constant zero, unaffected by writes.
// - Back-to-back bit 7 and double rate bit 5 always read zero.
// - Reserved status bit 6 and bits 4:0 read zero.
// - Memory base bits 15:4 are writable and give bottom address bits 31:20.
// - Memory window bottom has its twenty low address bits zero.
// - Memory limit bits 15:4 are writable and give top address bits 31:20.
// - Memory window top has its twenty low address bits all ones.
// - Bits 3:0 of memory base and limit are reserved and read zero.
// - Memory base and limit decide whether a memory access is forwarded.
// - Status register reports the internal bus between upstream and downstream ports.
// - I/O window bottom takes bits 15:12 from the base field, low bits zero.
`timescale 1ns/1ns
`default_nettype none

module bwc_regs
    import bwc_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire bwc_pkg::bwc_cfg_req_t cfgReq,
    output var  logic [7:0]           cfgRdData,
    output var  logic                 cfgRdValid,
    input  wire logic [3:0]           ioBottomBits,
    input  wire logic [15:0]          ioBaseUpper,
    input  wire logic [15:0]          ioLimitUpper,
    input  wire logic                 ioReqValid,
    input  wire logic [31:0]          ioReqAddr,
    input  wire logic                 memReqValid,
    input  wire logic [31:0]          memReqAddr,
    output var  logic                 ioForward,
    output var  logic                 memForward,
    output var  bwc_pkg::bwc_window_t ioWindow,
    output var  bwc_pkg::bwc_window_t memWindow
);
    import bwc_pkg::*;

    logic [3:0]  ioTopBits;
    logic [11:0] memBottomBits;
    logic [11:0] memTopBits;
    logic [15:0] statusWord;
    logic [7:0]  next_cfgRdData;
    bwc_window_t next_ioWindow;
    bwc_window_t next_memWindow;

    // Inclusive window test, shared by the I/O and memory paths
    function automatic logic inWindow(input logic [31:0] addr, input bwc_window_t win);
        inWindow = (addr >= win.bottom) && (addr <= win.top);
    endfunction : inWindow

    // Nothing is checked on the internal bus, so its status is constant
    assign statusWord = BUS_STATUS_VALUE;

    // I/O limit nibble; the type code has no storage, so writes cannot touch it
    always_ff @(posedge clk) begin
        if (rst) begin
            ioTopBits <= IO_TOP_RESET;
        end else if (cfgReq.write && cfgReq.offset == IO_LIMIT_OFS) begin
            ioTopBits <= cfgReq.wrData[TOP_NIBBLE_MSB:TOP_NIBBLE_LSB];
        end
    end

    // Memory base field, low nibble of the low byte is reserved
    always_ff @(posedge clk) begin
        if (rst) begin
            memBottomBits <= MEM_BITS_RESET;
        end else if (cfgReq.write && cfgReq.offset == MEM_BASE_LO_OFS) begin
            memBottomBits[3:0] <= cfgReq.wrData[TOP_NIBBLE_MSB:TOP_NIBBLE_LSB];
        end else if (cfgReq.write && cfgReq.offset == MEM_BASE_HI_OFS) begin
            memBottomBits[11:4] <= cfgReq.wrData;
        end
    end

    // Memory limit field; resets with every bit clear, reserved bits 3:0 are not stored
    always_ff @(posedge clk) begin
        if (rst) begin
            memTopBits <= MEM_BITS_RESET;
        end else if (cfgReq.write && cfgReq.offset == MEM_LIMIT_LO_OFS) begin
            memTopBits[3:0] <= cfgReq.wrData[TOP_NIBBLE_MSB:TOP_NIBBLE_LSB];
        end else if (cfgReq.write && cfgReq.offset == MEM_LIMIT_HI_OFS) begin
            memTopBits[11:4] <= cfgReq.wrData;
        end
    end

    // Read mux; unmapped offsets answer zero rather than stalling the read
    always_comb begin
        unique case (cfgReq.offset)
            IO_LIMIT_OFS:      next_cfgRdData = {ioTopBits, IO_WIDTH_CODE};
            BUS_STATUS_LO_OFS: next_cfgRdData = statusWord[7:0];
            BUS_STATUS_HI_OFS: next_cfgRdData = statusWord[15:8];
            MEM_BASE_LO_OFS:   next_cfgRdData = {memBottomBits[3:0], RSVD_NIBBLE};
            MEM_BASE_HI_OFS:   next_cfgRdData = memBottomBits[11:4];
            MEM_LIMIT_LO_OFS:  next_cfgRdData = {memTopBits[3:0], RSVD_NIBBLE};
            MEM_LIMIT_HI_OFS:  next_cfgRdData = memTopBits[11:4];
            default:           next_cfgRdData = UNMAPPED_BYTE;
        endcase
    end

    // Read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgRdData  <= UNMAPPED_BYTE;
            cfgRdValid <= 1'b0;
        end else begin
            cfgRdData  <= cfgReq.read ? next_cfgRdData : UNMAPPED_BYTE;
            cfgRdValid <= cfgReq.read;
        end
    end

    // Expanded window bounds
    always_comb begin
        next_ioWindow.bottom  = {ioBaseUpper, ioBottomBits, IO_LOW_ZEROS};
        next_ioWindow.top     = {ioLimitUpper, ioTopBits, IO_LOW_ONES};
        next_memWindow.bottom = {memBottomBits, MEM_LOW_ZEROS};
        next_memWindow.top    = {memTopBits, MEM_LOW_ONES};
    end

    // Registered bounds; they trail a register write by one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            ioWindow  <= '0;
            memWindow <= '0;
        end else begin
            ioWindow  <= next_ioWindow;
            memWindow <= next_memWindow;
        end
    end

    // Forwarding decisions, judged against the current register contents
    always_ff @(posedge clk) begin
        if (rst) begin
            ioForward  <= 1'b0;
            memForward <= 1'b0;
        end else begin
            ioForward  <= ioReqValid && inWindow(ioReqAddr, next_ioWindow);
            memForward <= memReqValid && inWindow(memReqAddr, next_memWindow);
        end
    end

endmodule : bwc_regs

`default_nettype wire

// file: verif/bwc_regs_checker.sv
// Checker: port assertions for the bridge window registers
`timescale 1ns/1ns
`default_nettype none
module bwc_regs_checker
    import bwc_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rst,
    input wire bwc_pkg::bwc_cfg_req_t cfgReq,
    input wire logic [7:0]            cfgRdData,
    input wire logic                  cfgRdValid,
    input wire logic [3:0]            ioBottomBits,
    input wire logic [15:0]           ioBaseUpper,
    input wire logic [15:0]           ioLimitUpper,
    input wire logic                  ioReqValid,
    input wire logic [31:0]           ioReqAddr,
    input wire logic                  ioForward,
    input wire logic                  memReqValid,
    input wire logic [31:0]           memReqAddr,
    input wire logic                  memForward,
    input wire bwc_pkg::bwc_window_t  ioWindow,
    input wire bwc_pkg::bwc_window_t  memWindow
);
    // One clock domain; windows lag their sources by one edge, so reset edges are skipped
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] o); cfgReq.read && cfgReq.offset == o; endsequence
    sequence s_wr21; cfgReq.write && cfgReq.offset == 8'h21; endsequence
    a_rd_answer: assert property (cfgReq.read |=> cfgRdValid)
        else $error("read not answered");
    a_status_zero: assert property (cfgReq.read && cfgReq.offset[7:1] == 7'h0F |=> cfgRdData == 8'h00)
        else $error("status byte not zero");
    a_io_type: assert property (s_rd(8'h1D) |=> cfgRdData[3:0] == 4'h1)
        else $error("io width code wrong");
    a_mem_rsvd: assert property (cfgReq.read && cfgReq.offset inside {8'h20, 8'h22} |=> cfgRdData[3:0] == 4'h0)
        else $error("memory reserved bits set");
    a_base_hold: assert property (s_wr21 ##1 s_rd(8'h21) |=> cfgRdData == $past(cfgReq.wrData, 2))
        else $error("memory base byte lost");
    a_io_bottom: assert property (!$past(rst) |-> ioWindow.bottom == {$past(ioBaseUpper), $past(ioBottomBits), 12'h000})
        else $error("io bottom wrong");
    a_io_top: assert property (!$past(rst) |-> ioWindow.top[31:16] == $past(ioLimitUpper) && ioWindow.top[11:0] == 12'hFFF)
        else $error("io top wrong");
    a_mem_fill: assert property (!$past(rst) |-> memWindow.bottom[19:0] == 20'h0_0000 && memWindow.top[19:0] == 20'hF_FFFF)
        else $error("memory fill wrong");
    // The bounds shown one edge later are exactly the ones the decision used
    a_mem_judge: assert property (memReqValid |=> memForward == ($past(memReqAddr) >= memWindow.bottom && $past(memReqAddr) <= memWindow.top))
        else $error("memory forward wrong");
    a_io_judge: assert property (ioReqValid |=> ioForward == ($past(ioReqAddr) >= ioWindow.bottom && $past(ioReqAddr) <= ioWindow.top))
        else $error("io forward wrong");
    a_mem_idle: assert property (!memReqValid |=> !memForward)
        else $error("forward without request");
endmodule : bwc_regs_checker
bind bwc_regs bwc_regs_checker i_bwc_regs_checker (.clk(clk), .rst(rst), .cfgReq(cfgReq),
    .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .ioBottomBits(ioBottomBits),
    .ioBaseUpper(ioBaseUpper), .ioLimitUpper(ioLimitUpper), .ioReqValid(ioReqValid),
    .ioReqAddr(ioReqAddr), .ioForward(ioForward), .memReqValid(memReqValid),
    .memReqAddr(memReqAddr), .memForward(memForward), .ioWindow(ioWindow), .memWindow(memWindow));
`default_nettype wire

// file: verif/bwc_regs_test.sv
// Testbench: register access and window forwarding of the bridge window registers
`timescale 1ns/1ns
`default_nettype none
module bwc_regs_test;
    import bwc_pkg::*;
    logic clk, rst, cfgRdValid, ioReqValid, memReqValid, ioForward, memForward;
    bwc_cfg_req_t cfgReq;
    logic [7:0]   cfgRdData;
    logic [3:0]   ioBottomBits;
    logic [15:0]  ioBaseUpper, ioLimitUpper;
    logic [31:0]  ioReqAddr, memReqAddr;
    bwc_window_t  ioWindow, memWindow;
    int err_count, compares, cycles;
    // Read-back after writing all ones from 0x1C to 0x24; edges are unmapped
    logic [7:0]   allOnes [9] = '{8'h00, 8'hF1, 8'h00, 8'h00, 8'hF0, 8'hFF, 8'hF0, 8'hFF, 8'h00};
    bwc_regs i_bwc_regs (.clk(clk), .rst(rst), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid), .ioBottomBits(ioBottomBits), .ioBaseUpper(ioBaseUpper),
        .ioLimitUpper(ioLimitUpper), .ioReqValid(ioReqValid), .ioReqAddr(ioReqAddr),
        .memReqValid(memReqValid), .memReqAddr(memReqAddr), .ioForward(ioForward),
        .memForward(memForward), .ioWindow(ioWindow), .memWindow(memWindow));
    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard: the run needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            err_count++;
            final_report();
        end
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // One access stands from this edge to the next; reads repeat harmlessly
    task acc(input logic w, input logic r, input logic [7:0] o, input logic [7:0] d);
        cfgReq <= '{w, r, o, d};
        @(posedge clk);
    endtask : acc
    task rd(input logic [7:0] o, input logic [7:0] e);
        acc(1'b0, 1'b1, o, 8'h00);
        #1 chk({24'h0, cfgRdData}, {24'h0, e});
        chk({31'h0, cfgRdValid}, 32'h1);
        @(posedge clk);
    endtask : rd
    // Probe answer checked one edge after it is driven; a second edge spaces the probes
    task fwd(input logic io, input logic [31:0] a, input logic e);
        cfgReq <= '0;
        ioReqValid <= io;
        memReqValid <= !io;
        ioReqAddr <= a;
        memReqAddr <= a;
        @(posedge clk);
        #1 chk({31'h0, io ? ioForward : memForward}, {31'h0, e});
        @(posedge clk);
    endtask : fwd
    task t_reset;
        for (int i = 0; i < 7; i++) rd(8'(8'h1D + i), i == 0 ? 8'h01 : 8'h00);
    endtask : t_reset
    task t_ones;
        for (int i = 0; i < 9; i++) acc(1'b1, 1'b0, 8'(8'h1C + i), 8'hFF);
        for (int i = 0; i < 9; i++) rd(8'(8'h1C + i), allOnes[i]);
        chk(memWindow.bottom, 32'hFFF0_0000);
        chk(memWindow.top, 32'hFFFF_FFFF);
        chk(ioWindow.top, 32'h0001_FFFF);
        chk(ioWindow.bottom, 32'h0001_3000);
    endtask : t_ones
    task t_mem;
        acc(1'b1, 1'b0, 8'h21, 8'h12);
        rd(8'h21, 8'h12);
        acc(1'b1, 1'b0, 8'h20, 8'h30);
        acc(1'b1, 1'b0, 8'h22, 8'h50);
        acc(1'b1, 1'b0, 8'h23, 8'h12);
        fwd(1'b0, 32'h122F_FFFF, 1'b0);
        fwd(1'b0, 32'h1230_0000, 1'b1);
        fwd(1'b0, 32'h125F_FFFF, 1'b1);
        fwd(1'b0, 32'h1260_0000, 1'b0);
    endtask : t_mem
    task t_io;
        acc(1'b1, 1'b0, 8'h1D, 8'h5F);
        fwd(1'b1, 32'h0001_2FFF, 1'b0);
        fwd(1'b1, 32'h0001_3000, 1'b1);
        fwd(1'b1, 32'h0001_5FFF, 1'b1);
        fwd(1'b1, 32'h0001_6000, 1'b0);
    endtask : t_io
    // Mid-run reset after writes must bring every register back
    task t_rerst;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
    endtask : t_rerst
    task final_report;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    // Main sequence: reset for 8 cycles, then the scenarios
    initial begin
        rst = 1'b1;
        cfgReq = '0;
        {ioReqValid, memReqValid, ioReqAddr, memReqAddr} = '0;
        ioBottomBits = 4'h3;
        ioBaseUpper = 16'h0001;
        ioLimitUpper = 16'h0001;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ones();
        t_mem();
        t_io();
        t_rerst();
        final_report();
    end
endmodule : bwc_regs_test
`default_nettype wire
